// *** verilog/ptd_defs.svh ***
`ifndef PTD_DEFS_SVH
`define PTD_DEFS_SVH
// sample and memory geometry
`define PTD_DATA_W      10
`define PTD_PTR_W       8
`define PTD_DEPTH       192
`define PTD_MAX_DELAY   8'hc0
`define PTD_LAST_ADDR   8'hbf
`define PTD_WRAP_ADD    9'h0c0
// reset values
`define PTD_WP_RST      8'h00
`define PTD_CFG_RST     9'h000
`define PTD_DATA_RST    10'h000
// output buffer
`define PTD_FIFO_DEPTH  16
`endif

// *** verilog/ptd_pkg.sv ***
`default_nettype none
package ptd_pkg;
    // delay setting together with the channel enable
    typedef struct packed {
        logic       en;
        logic [7:0] delay;
    } ptd_cfg_type;

    // route taken by the samples
    typedef enum logic [1:0] {
        PTD_DIRECT,
        PTD_ONE_REG,
        PTD_MEMORY
    } ptd_path_type;
endpackage : ptd_pkg
`default_nettype wire

// *** verilog/ptd_delay_line.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ptd_defs.svh"

// ****************************************************************
// triple voted register
// ****************************************************************
module ptd_vote_reg #(
    parameter int              W   = 8,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    input  wire logic [W-1:0]  d_in,
    output logic      [W-1:0]  q_out
);
    logic [W-1:0] a_r;
    logic [W-1:0] b_r;
    logic [W-1:0] c_r;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            a_r <= RST;
            b_r <= RST;
            c_r <= RST;
        end else begin
            a_r <= d_in;
            b_r <= d_in;
            c_r <= d_in;
        end
    end

    // a single upset copy is outvoted
    assign q_out = (a_r & b_r) | (a_r & c_r) | (b_r & c_r);
endmodule : ptd_vote_reg

// ****************************************************************
// output buffer
// ****************************************************************
module ptd_fifo #(
    parameter int W     = 10,
    parameter int DEPTH = 16
) (
    input  wire logic          clk_in,
    input  wire logic          rst_in,
    // fill side
    input  wire logic          in_valid_in,
    output logic               in_ready_out,
    input  wire logic [W-1:0]  in_data_in,
    output logic               almost_full_out,
    // drain side
    output logic               out_valid_out,
    input  wire logic          out_ready_in,
    output logic      [W-1:0]  out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  buf_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready_out    = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out   = (cnt_r != '0);
    assign almost_full_out = (cnt_r >= (AW+1)'(DEPTH - 1));
    assign out_data_out    = buf_r[rd_r];
    assign push            = in_valid_in && in_ready_out;
    assign pop             = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            buf_r[wr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ptd_fifo

// ****************************************************************
// pre-trigger sample delay line
// ****************************************************************
module ptd_delay_line #(
    parameter int DATA_W     = `PTD_DATA_W,
    parameter int FIFO_DEPTH = `PTD_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic               sys_clk_in,
    input  wire logic               sys_rst_in,
    // configuration
    input  wire logic [7:0]         trigger_delay_setting_in,
    input  wire logic               channel_enable_in,
    // sample input
    input  wire logic               sample_valid_in,
    output logic                    sample_ready_out,
    input  wire logic [DATA_W-1:0]  sample_data_in,
    // delayed sample output
    output logic                    delayed_valid_out,
    input  wire logic               delayed_ready_in,
    output logic      [DATA_W-1:0]  delayed_data_out
);
    logic [DATA_W-1:0]    mem_r [`PTD_DEPTH];
    ptd_pkg::ptd_cfg_type cfg_nxt;
    ptd_pkg::ptd_cfg_type cfg;
    ptd_pkg::ptd_path_type path;
    logic [7:0]           wp;
    logic [7:0]           wp_nxt;
    logic [7:0]           rp;
    logic [7:0]           norm;
    logic                 mem_ce;
    logic [DATA_W-1:0]    mem_wdata;
    logic [DATA_W-1:0]    mem_q_r;
    logic [DATA_W-1:0]    one_r;
    logic [7:0]           fill_r;
    logic                 in_ready_r;
    logic                 adv;
    logic [DATA_W-1:0]    push_data;
    logic                 fifo_valid;
    logic                 fifo_af;
    logic                 fifo_pop;
    logic [DATA_W-1:0]    fifo_data;
    logic                 out_valid_r;
    logic [DATA_W-1:0]    out_data_r;

    // ************************************************************
    // configuration
    // ************************************************************
    // settings above the memory size are clamped to the largest delay
    always_comb begin
        cfg_nxt.en    = channel_enable_in;
        cfg_nxt.delay = (trigger_delay_setting_in > `PTD_MAX_DELAY)
                        ? `PTD_MAX_DELAY : trigger_delay_setting_in;
    end

    ptd_vote_reg #(.W(9), .RST(`PTD_CFG_RST)) u_cfg_reg (
        .clk_in (sys_clk_in),
        .rst_in (sys_rst_in),
        .d_in   (cfg_nxt),
        .q_out  (cfg)
    );

    always_comb begin
        case (cfg.delay)
            8'h00:   path = ptd_pkg::PTD_DIRECT;
            8'h01:   path = ptd_pkg::PTD_ONE_REG;
            default: path = ptd_pkg::PTD_MEMORY;
        endcase
    end

    // ************************************************************
    // pointers
    // ************************************************************
    // a sample moves only when the output buffer can take its result
    assign adv       = sample_valid_in && in_ready_r;
    assign mem_ce    = (path == ptd_pkg::PTD_MEMORY) && cfg.en;
    // memory adds one cycle of its own, so one less is addressed
    assign norm      = cfg.delay - 8'h01;
    // quiet data pins save the toggling power of an idle memory
    assign mem_wdata = mem_ce ? sample_data_in : `PTD_DATA_RST;

    always_comb begin
        if (mem_ce && adv) begin
            wp_nxt = (wp == `PTD_LAST_ADDR) ? 8'h00 : wp + 8'h01;
        end else begin
            wp_nxt = wp;
        end
    end

    ptd_vote_reg #(.W(8), .RST(`PTD_WP_RST)) u_wp_reg (
        .clk_in (sys_clk_in),
        .rst_in (sys_rst_in),
        .d_in   (wp_nxt),
        .q_out  (wp)
    );

    // read pointer trails by norm, which is at least one
    always_comb begin
        if (wp >= norm) begin
            rp = wp - norm;
        end else begin
            rp = 8'({1'b0, wp} + `PTD_WRAP_ADD - {1'b0, norm});
        end
    end

    // ************************************************************
    // data paths
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (mem_ce && adv) begin
            mem_r[wp] <= mem_wdata;
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mem_q_r <= `PTD_DATA_RST;
        end else if (mem_ce && adv) begin
            mem_q_r <= mem_r[rp];
        end
    end

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            one_r <= `PTD_DATA_RST;
        end else if (adv) begin
            one_r <= sample_data_in;
        end
    end

    // counts samples seen since reset or a new setting, saturating
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            fill_r <= 8'h00;
        end else if (cfg_nxt != cfg) begin
            fill_r <= 8'h00;
        end else if (adv && fill_r != `PTD_MAX_DELAY) begin
            fill_r <= fill_r + 8'h01;
        end
    end

    always_comb begin
        if (!cfg.en || fill_r < cfg.delay) begin
            push_data = `PTD_DATA_RST;
        end else begin
            case (path)
                ptd_pkg::PTD_DIRECT:  push_data = sample_data_in;
                ptd_pkg::PTD_ONE_REG: push_data = one_r;
                default:              push_data = mem_q_r;
            endcase
        end
    end

    // ************************************************************
    // output buffer and output register
    // ************************************************************
    ptd_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in          (sys_clk_in),
        .rst_in          (sys_rst_in),
        .in_valid_in     (adv),
        .in_ready_out    (),
        .in_data_in      (push_data),
        .almost_full_out (fifo_af),
        .out_valid_out   (fifo_valid),
        .out_ready_in    (fifo_pop),
        .out_data_out    (fifo_data)
    );

    // ready is registered, so it drops one entry early
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            in_ready_r <= 1'b0;
        end else begin
            in_ready_r <= !fifo_af;
        end
    end

    assign fifo_pop = fifo_valid && (!out_valid_r || delayed_ready_in);

    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_valid_r <= 1'b0;
            out_data_r  <= `PTD_DATA_RST;
        end else if (!out_valid_r || delayed_ready_in) begin
            out_valid_r <= fifo_valid;
            out_data_r  <= fifo_pop ? fifo_data : `PTD_DATA_RST;
        end
    end

    assign sample_ready_out  = in_ready_r;
    assign delayed_valid_out = out_valid_r;
    assign delayed_data_out  = out_data_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_reg_two_adv;
        (path == ptd_pkg::PTD_ONE_REG && adv && cfg.en) ##1
        (path == ptd_pkg::PTD_ONE_REG && adv && cfg.en && fill_r >= 8'h01);
    endsequence
    property p_ptr_apart;
        mem_ce |-> (rp != wp) && (rp <= `PTD_LAST_ADDR);
    endproperty
    a_ptr_apart: assert property (p_ptr_apart)
        else $error("read pointer met write pointer");
    property p_wp_wrap;
        (mem_ce && adv && wp == `PTD_LAST_ADDR) |=> (wp == 8'h00);
    endproperty
    a_wp_wrap: assert property (p_wp_wrap)
        else $error("write pointer did not wrap");
    property p_wp_step;
        (mem_ce && adv && wp < `PTD_LAST_ADDR) |=> (wp == $past(wp) + 8'h01);
    endproperty
    a_wp_step: assert property (p_wp_step)
        else $error("write pointer did not step");
    property p_wp_hold;
        !mem_ce |=> (wp == $past(wp));
    endproperty
    a_wp_hold: assert property (p_wp_hold)
        else $error("write pointer moved while memory off");
    property p_wdata_zero;
        !mem_ce |-> (mem_wdata == `PTD_DATA_RST);
    endproperty
    a_wdata_zero: assert property (p_wdata_zero)
        else $error("memory write data not zero while off");
    property p_rp_direct;
        (mem_ce && wp >= cfg.delay - 8'h01) |-> (rp + cfg.delay - 8'h01 == wp);
    endproperty
    a_rp_direct: assert property (p_rp_direct)
        else $error("read pointer wrong without wrap");
    property p_rp_wrap;
        (mem_ce && wp < cfg.delay - 8'h01)
            |-> (9'(rp) + 9'(cfg.delay) - 9'h001 == 9'(wp) + `PTD_WRAP_ADD);
    endproperty
    a_rp_wrap: assert property (p_rp_wrap)
        else $error("read pointer wrong with wrap");
    property p_direct;
        (path == ptd_pkg::PTD_DIRECT && cfg.en) |-> (push_data == sample_data_in);
    endproperty
    a_direct: assert property (p_direct)
        else $error("zero delay did not pass through");
    property p_one_reg;
        s_reg_two_adv |-> (push_data == $past(sample_data_in));
    endproperty
    a_one_reg: assert property (p_one_reg)
        else $error("unit delay did not use one register");
    property p_ce_off;
        (path != ptd_pkg::PTD_MEMORY) |-> !mem_ce ##1 (wp == $past(wp));
    endproperty
    a_ce_off: assert property (p_ce_off)
        else $error("memory enabled off its path");
endmodule : ptd_delay_line
`default_nettype wire

// *** bench/ptd_stream_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// sample source and downstream consumer model
// ****************************************************************
module ptd_stream_partner (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // control from the bench
    input  wire logic        restart_in,
    input  wire logic        src_en_in,
    input  wire logic        src_stall_in,
    input  wire logic        snk_en_in,
    input  wire logic        snk_stall_in,
    input  wire logic [9:0]  base_in,
    input  wire logic [15:0] src_max_in,
    // stream into the block
    output logic             sample_valid_out,
    input  wire logic        sample_ready_in,
    output logic      [9:0]  sample_data_out,
    // stream out of the block
    input  wire logic        delayed_valid_in,
    output logic             delayed_ready_out,
    input  wire logic [9:0]  delayed_data_in
);
    logic [9:0] rx_q[$];
    int         sent;
    int         cyc;
    logic       taken;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sent <= 0;
            cyc <= 0;
            taken <= 1'b0;
        end else begin
            cyc <= cyc + 1;
            taken <= sample_valid_out && sample_ready_in;
            if (restart_in) begin
                sent <= 0;
                rx_q.delete();
            end else begin
                if (sample_valid_out && sample_ready_in) begin
                    sent <= sent + 1;
                end
                if (delayed_valid_in && delayed_ready_out) begin
                    rx_q.push_back(delayed_data_in);
                end
            end
        end
    end

    // an offer is held unchanged until the block has taken it
    always @(negedge clk_in) begin
        logic go;
        go = src_en_in && (sent < int'(src_max_in))
             && !(src_stall_in && cyc[1:0] == 2'h0);
        if (rst_in) begin
            sample_valid_out <= 1'b0;
            sample_data_out <= 10'h000;
        end else if (!sample_valid_out || taken) begin
            sample_valid_out <= go;
            // an idle data bus toggles between the stale sample and its inverse
            sample_data_out <= go ? base_in + sent[9:0] : ~sample_data_out;
        end
        delayed_ready_out <= snk_en_in && !(snk_stall_in && cyc[2]);
    end
endmodule : ptd_stream_partner
`default_nettype wire

// *** bench/tb_ptd_delay_line.sv ***
`timescale 1ns/10ps
`default_nettype none
`define PTD_CHK(got, exp, msg) \
    begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", \
             $time, msg, got, exp); end end
module tb_ptd_delay_line;
    logic        sys_clk_in;
    logic        sys_rst_in;
    logic [7:0]  delay_set;
    logic        chan_en;
    logic        s_valid, s_ready, d_valid, d_ready;
    logic [9:0]  s_data, d_data, base;
    logic        restart, src_en, src_stall, snk_en, snk_stall;
    logic [15:0] src_max;
    int          error_cnt, num_checks;

    ptd_delay_line i_dut (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .trigger_delay_setting_in(delay_set), .channel_enable_in(chan_en),
        .sample_valid_in(s_valid), .sample_ready_out(s_ready),
        .sample_data_in(s_data), .delayed_valid_out(d_valid),
        .delayed_ready_in(d_ready), .delayed_data_out(d_data)
    );

    ptd_stream_partner i_partner (
        .clk_in(sys_clk_in), .rst_in(sys_rst_in), .restart_in(restart),
        .src_en_in(src_en), .src_stall_in(src_stall), .snk_en_in(snk_en),
        .snk_stall_in(snk_stall), .base_in(base), .src_max_in(src_max),
        .sample_valid_out(s_valid), .sample_ready_in(s_ready),
        .sample_data_out(s_data), .delayed_valid_in(d_valid),
        .delayed_ready_out(d_ready), .delayed_data_in(d_data)
    );

    initial begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    task cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // toggling the enable restarts the fill count between scenarios
    task set_cfg(input logic [7:0] d, input logic en);
        chan_en <= 1'b0;
        cyc(3);
        delay_set <= d;
        chan_en <= en;
        cyc(3);
        restart <= 1'b1;
        base <= base + 10'h025;
        cyc(1);
        restart <= 1'b0;
    endtask : set_cfg

    task wait_rx(input int n);
        int k;
        k = 0;
        while (i_partner.rx_q.size() < n && k < 3000) begin
            cyc(1);
            k++;
        end
        if (i_partner.rx_q.size() < n) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t too few output words", $time);
        end
    endtask : wait_rx

    task check_words(input int n, input int de, input logic en);
        logic [9:0] exp, got;
        for (int k = 0; k < n; k++) begin
            got = i_partner.rx_q[k];
            exp = (!en || k < de) ? 10'h000 : base + 10'(k - de);
            `PTD_CHK(got, exp, "word")
        end
    endtask : check_words

    task run_stream(input logic [7:0] d, input logic en, input int n,
                    input logic stall);
        set_cfg(d, en);
        src_max <= n[15:0];
        src_stall <= stall;
        snk_stall <= stall;
        snk_en <= 1'b1;
        src_en <= 1'b1;
        wait_rx(n);
        src_en <= 1'b0;
        check_words(n, (d > 8'hc0) ? 192 : int'(d), en);
    endtask : run_stream

    task t_reset;
        // the asynchronous reset is already applied; memory and buffer contents are never reset
        cyc(1);
        `PTD_CHK(s_ready, 1'b0, "ready in reset")
        `PTD_CHK(d_valid, 1'b0, "valid in reset")
        `PTD_CHK(d_data, 10'h000, "data in reset")
        cyc(1);
        sys_rst_in <= 1'b0;
        cyc(2);
        `PTD_CHK(s_ready, 1'b1, "ready after reset")
        $display("test reset done");
    endtask : t_reset

    task t_reset_mid;
        set_cfg(8'h04, 1'b1);
        src_max <= 16'h0040;
        snk_en <= 1'b0;
        src_en <= 1'b1;
        cyc(8);
        sys_rst_in <= 1'b1;
        src_en <= 1'b0;
        cyc(1);
        `PTD_CHK(s_ready, 1'b0, "ready in reset")
        `PTD_CHK(d_valid, 1'b0, "valid in reset")
        sys_rst_in <= 1'b0;
        cyc(2);
        `PTD_CHK(s_ready, 1'b1, "ready after reset")
        run_stream(8'h04, 1'b1, 12, 1'b0);
        $display("test reset in mid-run done");
    endtask : t_reset_mid

    task t_fill;
        set_cfg(8'h03, 1'b1);
        src_max <= 16'h0028;
        src_stall <= 1'b0;
        snk_en <= 1'b0;
        src_en <= 1'b1;
        cyc(40);
        `PTD_CHK(s_ready, 1'b0, "full buffer refuses")
        `PTD_CHK(i_partner.sent < 40, 1'b1, "nothing lost")
        snk_stall <= 1'b1;
        snk_en <= 1'b1;
        wait_rx(40);
        src_en <= 1'b0;
        check_words(40, 3, 1'b1);
        $display("test fill and drain done");
    endtask : t_fill

    task t_direct;
        run_stream(8'h00, 1'b1, 20, 1'b1);
        $display("test direct path done");
    endtask : t_direct

    task t_one_reg;
        run_stream(8'h01, 1'b1, 20, 1'b1);
        $display("test single register done");
    endtask : t_one_reg

    task t_mem_min;
        run_stream(8'h02, 1'b1, 30, 1'b0);
        $display("test shortest memory delay done");
    endtask : t_mem_min

    task t_mem_wrap;
        run_stream(8'hbf, 1'b1, 250, 1'b1);
        $display("test pointer wrap done");
    endtask : t_mem_wrap

    task t_mem_max;
        run_stream(8'hc0, 1'b1, 210, 1'b0);
        $display("test longest delay done");
    endtask : t_mem_max

    task t_clamp;
        run_stream(8'hff, 1'b1, 200, 1'b0);
        $display("test clamped delay done");
    endtask : t_clamp

    task t_disabled;
        run_stream(8'h05, 1'b0, 20, 1'b0);
        $display("test disabled channel done");
    endtask : t_disabled

    initial begin
        error_cnt = 0;
        num_checks = 0;
        sys_rst_in = 1'b1;
        delay_set = 8'h00;
        chan_en = 1'b0;
        restart = 1'b0;
        src_en = 1'b0;
        src_stall = 1'b0;
        snk_en = 1'b0;
        snk_stall = 1'b0;
        src_max = 16'h0000;
        base = 10'h100;
        t_reset;
        t_direct;
        t_one_reg;
        t_mem_min;
        t_mem_wrap;
        t_mem_max;
        t_clamp;
        t_disabled;
        t_fill;
        t_reset_mid;
        test_done;
    end

    // the whole run needs under two thousand cycles
    initial begin
        #300000;
        error_cnt++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        test_done;
    end
endmodule : tb_ptd_delay_line
`default_nettype wire
